// [design/rds_pkg.sv]
// Register map, field positions, reset values and state types of the redriver register bank.
package rds_pkg;

	// Seven-bit serial target address of the register port.
	localparam logic [6:0] RDS_TGT_ADDR = 7'h44;

	// Register offsets.
	localparam logic [7:0] RDS_OFF_MODE = 8'h0a;
	localparam logic [7:0] RDS_OFF_TXEQ = 8'h0b;
	localparam logic [7:0] RDS_OFF_EQ01 = 8'h10;
	localparam logic [7:0] RDS_OFF_EQ23 = 8'h11;
	localparam logic [7:0] RDS_OFF_SNOOP = 8'h12;
	localparam logic [7:0] RDS_OFF_LANE = 8'h13;

	// Reset values.
	localparam logic [7:0] RDS_RST_MODE = 8'h01;
	localparam logic [7:0] RDS_RST_TXEQ = 8'h6c;
	localparam logic [7:0] RDS_RST_EQ = 8'h00;
	localparam logic [7:0] RDS_RST_LANE = 8'h00;
	localparam logic [1:0] RDS_RST_PWR = 2'h0;
	localparam logic [4:0] RDS_RST_CNT = 5'h00;

	// Mode register fields.
	localparam int RDS_MODE_LIMITED = 7;
	localparam int RDS_MODE_EQREG = 4;
	localparam logic [7:0] RDS_MODE_WMASK = 8'hbf;

	// Transmit shaping and debug routing fields.
	localparam int RDS_TX_PRE_HI = 7;
	localparam int RDS_TX_PRE_EN = 5;
	localparam int RDS_TX_POST_HI = 4;
	localparam int RDS_TX_POST_EN = 2;

	// Lane control register fields.
	localparam int RDS_LANE_SNOOP_OFF = 7;
	localparam logic [7:0] RDS_LANE_WMASK = 8'hbf;

	// Observed sink addresses and the powered-up sink state.
	localparam logic [19:0] RDS_DPCD_POWER = 20'h00600;
	localparam logic [19:0] RDS_DPCD_LANES = 20'h00101;
	localparam logic [1:0] RDS_PWR_ON = 2'h1;

	// Path mode encodings.
	localparam logic [1:0] RDS_PATH_USB_DP2 = 2'h3;

	// Serial target states.
	typedef enum logic [3:0] {
		RDS_ST_IDLE,
		RDS_ST_ADDR,
		RDS_ST_ACK_ADDR,
		RDS_ST_PTR,
		RDS_ST_ACK_PTR,
		RDS_ST_WR,
		RDS_ST_ACK_WR,
		RDS_ST_RD,
		RDS_ST_RD_ACK
	} rds_i2c_state_t;

endpackage

// [design/rds_i2c_target.sv]
// Serial two-wire target that turns bus traffic into register writes and reads.
`timescale 1ns/1ps
module rds_i2c_target (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_oe,
	output logic [7:0] ptr,
	input wire logic [7:0] rd_data,
	output logic wr_pulse,
	output logic [7:0] wr_data
);
	import rds_pkg::*;

	rds_i2c_state_t state_reg; // Transfer state.
	logic scl_d_reg; // Previous clock line level.
	logic sda_d_reg; // Previous data line level.
	logic [7:0] sh_reg; // Shift register for both directions.
	logic [3:0] bits_reg; // Bits moved in the current byte.
	logic rw_reg; // High when the controller reads.
	logic nack_reg; // Controller refused the last read byte.
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// Edges and bus conditions from one cycle of history.
	assign scl_rise = scl && !scl_d_reg;
	assign scl_fall = !scl && scl_d_reg;
	assign start_seen = scl && scl_d_reg && sda_d_reg && !sda_i;
	assign stop_seen = scl && scl_d_reg && !sda_d_reg && sda_i;

	// Line history.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl;
			sda_d_reg <= sda_i;
		end
	end

	// Protocol engine: address, pointer, then data bytes with auto increment.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= RDS_ST_IDLE;
			sh_reg <= 8'h00;
			bits_reg <= 4'h0;
			rw_reg <= 1'b0;
			nack_reg <= 1'b0;
			sda_oe <= 1'b0;
			ptr <= 8'h00;
			wr_pulse <= 1'b0;
			wr_data <= 8'h00;
		end else begin
			wr_pulse <= 1'b0;
			if (start_seen) begin
				// A start or repeated start always restarts addressing.
				state_reg <= RDS_ST_ADDR;
				bits_reg <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_seen) begin
				state_reg <= RDS_ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state_reg)
					RDS_ST_ADDR, RDS_ST_PTR, RDS_ST_WR: begin
						if (scl_rise) begin
							sh_reg <= {sh_reg[6:0], sda_i};
							bits_reg <= bits_reg + 4'h1;
						end else if (scl_fall && bits_reg == 4'h8) begin
							sda_oe <= 1'b1;
							if (state_reg == RDS_ST_ADDR) begin
								// Another target's address leaves the bus alone.
								if (sh_reg[7:1] == RDS_TGT_ADDR) begin
									rw_reg <= sh_reg[0];
									state_reg <= RDS_ST_ACK_ADDR;
								end else begin
									sda_oe <= 1'b0;
									state_reg <= RDS_ST_IDLE;
								end
							end else if (state_reg == RDS_ST_PTR) begin
								ptr <= sh_reg;
								state_reg <= RDS_ST_ACK_PTR;
							end else begin
								wr_pulse <= 1'b1;
								wr_data <= sh_reg;
								state_reg <= RDS_ST_ACK_WR;
							end
						end
					end
					RDS_ST_ACK_ADDR, RDS_ST_ACK_PTR, RDS_ST_ACK_WR: begin
						if (scl_fall) begin
							bits_reg <= 4'h0;
							sda_oe <= 1'b0;
							if (state_reg == RDS_ST_ACK_WR) begin
								ptr <= ptr + 8'h01;
								state_reg <= RDS_ST_WR;
							end else if (state_reg == RDS_ST_ACK_PTR) begin
								state_reg <= RDS_ST_WR;
							end else if (rw_reg) begin
								// First read byte comes from the current pointer.
								sh_reg <= rd_data;
								sda_oe <= !rd_data[7];
								ptr <= ptr + 8'h01;
								state_reg <= RDS_ST_RD;
							end else begin
								state_reg <= RDS_ST_PTR;
							end
						end
					end
					RDS_ST_RD: begin
						if (scl_rise) begin
							bits_reg <= bits_reg + 4'h1;
						end else if (scl_fall) begin
							if (bits_reg == 4'h8) begin
								sda_oe <= 1'b0;
								state_reg <= RDS_ST_RD_ACK;
							end else begin
								sda_oe <= !sh_reg[6];
								sh_reg <= {sh_reg[6:0], 1'b0};
							end
						end
					end
					RDS_ST_RD_ACK: begin
						if (scl_rise) begin
							nack_reg <= sda_i;
						end else if (scl_fall) begin
							bits_reg <= 4'h0;
							if (nack_reg) begin
								state_reg <= RDS_ST_IDLE;
							end else begin
								sh_reg <= rd_data;
								sda_oe <= !rd_data[7];
								ptr <= ptr + 8'h01;
								state_reg <= RDS_ST_RD;
							end
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// [design/rds_regs.sv]
// Redriver configuration and snoop status register bank behind a two-wire target port.
`timescale 1ns/1ps

module rds_regs (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [1:0] eq_strap_pins,
	input wire logic aux_wr_valid,
	input wire logic [19:0] aux_wr_addr,
	input wire logic [7:0] aux_wr_data,
	output logic [1:0] precursor_level,
	output logic precursor_on,
	output logic [1:0] postcursor_level,
	output logic postcursor_on,
	output logic [1:0] debug_route_ctrl,
	output logic limited_mode_select,
	output logic eq_from_registers,
	output logic [1:0] path_mode_select,
	output logic [3:0] lane0_eq_code,
	output logic [3:0] lane1_eq_code,
	output logic [3:0] lane2_eq_code,
	output logic [3:0] lane3_eq_code,
	output logic [3:0] lane_enable
);
	import rds_pkg::*;

	logic [7:0] mode_reg; // Path mode, equalization source and transmitter mode.
	logic [7:0] txeq_reg; // Transmit shaping and debug routing.
	logic [7:0] eq01_reg; // Lane 0 and 1 equalization codes.
	logic [7:0] eq23_reg; // Lane 2 and 3 equalization codes.
	logic [1:0] pwr_reg; // Captured sink power state.
	logic [4:0] cnt_reg; // Captured lane count.
	logic [7:0] lane_reg; // Snoop disable and per-lane off bits.
	logic [1:0] strap_reg; // Strap level caught after reset.
	logic strap_done_reg; // High once the strap level is caught.
	logic dp_on_d_reg; // Previous display path bit, for edge detection.
	logic [7:0] ptr;
	logic [7:0] rd_data;
	logic wr_pulse;
	logic [7:0] wr_data;
	logic [7:0] strap_code;
	logic dp_on;
	logic snoop_on;
	logic [3:0] lane_next;
	logic [3:0] dp_allowed;

	assign strap_code = {2'h0, strap_reg, 2'h0, strap_reg};
	assign dp_on = mode_reg[1];
	assign snoop_on = !lane_reg[RDS_LANE_SNOOP_OFF];

	// The serial port turns bus bytes into register traffic.
	rds_i2c_target u_port (
		.mclk(mclk),
		.resetn(resetn),
		.scl(scl),
		.sda_i(sda_i),
		.sda_oe(sda_oe),
		.ptr(ptr),
		.rd_data(rd_data),
		.wr_pulse(wr_pulse),
		.wr_data(wr_data)
	);

	// The data line is open drain, so only a low level is ever driven.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strap_reg <= 2'h0;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_reg <= eq_strap_pins;
			strap_done_reg <= 1'b1;
		end
	end

	// mode register writes, reserved bit 6 stays zero.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= RDS_RST_MODE;
		end else if (wr_pulse && ptr == RDS_OFF_MODE) begin
			mode_reg <= wr_data & RDS_MODE_WMASK;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			txeq_reg <= RDS_RST_TXEQ;
		end else if (wr_pulse && ptr == RDS_OFF_TXEQ) begin
			txeq_reg <= wr_data;
		end
	end

	// lane control writes, reserved bit 6 stays zero.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lane_reg <= RDS_RST_LANE;
		end else if (wr_pulse && ptr == RDS_OFF_LANE) begin
			lane_reg <= wr_data & RDS_LANE_WMASK;
		end
	end

	// equalization fields: straps mirrored, or software codes kept.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			eq01_reg <= RDS_RST_EQ;
			eq23_reg <= RDS_RST_EQ;
		end else if (!mode_reg[RDS_MODE_EQREG]) begin
			// Hardware owns the fields, so software writes are lost here.
			eq01_reg <= strap_code;
			eq23_reg <= strap_code;
		end else if (wr_pulse && ptr == RDS_OFF_EQ01) begin
			eq01_reg <= wr_data;
		end else if (wr_pulse && ptr == RDS_OFF_EQ23) begin
			eq23_reg <= wr_data;
		end
	end

	// snoop capture; a capture beats the clear in the same cycle.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pwr_reg <= RDS_RST_PWR;
			cnt_reg <= RDS_RST_CNT;
			dp_on_d_reg <= 1'b0;
		end else begin
			dp_on_d_reg <= dp_on;
			if (dp_on_d_reg && !dp_on) begin
				pwr_reg <= RDS_RST_PWR;
				cnt_reg <= RDS_RST_CNT;
			end
			if (aux_wr_valid && aux_wr_addr == RDS_DPCD_POWER) begin
				pwr_reg <= aux_wr_data[1:0];
			end
			if (aux_wr_valid && aux_wr_addr == RDS_DPCD_LANES) begin
				cnt_reg <= aux_wr_data[4:0];
			end
		end
	end

	// register read mux; status reads back bit 7 as zero.
	always_comb begin
		if (ptr == RDS_OFF_MODE) begin
			rd_data = mode_reg;
		end else if (ptr == RDS_OFF_TXEQ) begin
			rd_data = txeq_reg;
		end else if (ptr == RDS_OFF_EQ01) begin
			rd_data = eq01_reg;
		end else if (ptr == RDS_OFF_EQ23) begin
			rd_data = eq23_reg;
		end else if (ptr == RDS_OFF_SNOOP) begin
			rd_data = {1'b0, pwr_reg, cnt_reg};
		end else if (ptr == RDS_OFF_LANE) begin
			rd_data = lane_reg;
		end else begin
			// Unmapped offsets read as zero.
			rd_data = 8'h00;
		end
	end

	// lane enables from snoop or from per-lane off bits.
	always_comb begin
		// The shared mode leaves only the two lower lanes to the display path.
		dp_allowed = (mode_reg[1:0] == RDS_PATH_USB_DP2) ? 4'h3 : 4'hf;
		lane_next = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (snoop_on) begin
				lane_next[i] = (cnt_reg > 5'(i)) && (pwr_reg == RDS_PWR_ON);
			end else begin
				lane_next[i] = !lane_reg[i];
			end
		end
		if (!dp_on) begin
			lane_next = 4'h0;
		end else begin
			lane_next = lane_next & dp_allowed;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			precursor_level <= 2'h0;
			precursor_on <= 1'b0;
			postcursor_level <= 2'h0;
			postcursor_on <= 1'b0;
			debug_route_ctrl <= 2'h0;
			limited_mode_select <= 1'b0;
			eq_from_registers <= 1'b0;
			path_mode_select <= 2'h0;
		end else begin
			precursor_level <= txeq_reg[RDS_TX_PRE_HI -: 2];
			precursor_on <= txeq_reg[RDS_TX_PRE_EN] && mode_reg[RDS_MODE_LIMITED];
			postcursor_level <= txeq_reg[RDS_TX_POST_HI -: 2];
			postcursor_on <= txeq_reg[RDS_TX_POST_EN] && mode_reg[RDS_MODE_LIMITED];
			debug_route_ctrl <= txeq_reg[1:0];
			limited_mode_select <= mode_reg[RDS_MODE_LIMITED];
			eq_from_registers <= mode_reg[RDS_MODE_EQREG];
			path_mode_select <= mode_reg[1:0];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lane0_eq_code <= 4'h0;
			lane1_eq_code <= 4'h0;
			lane2_eq_code <= 4'h0;
			lane3_eq_code <= 4'h0;
			lane_enable <= 4'h0;
		end else begin
			lane0_eq_code <= eq01_reg[3:0];
			lane1_eq_code <= eq01_reg[7:4];
			lane2_eq_code <= eq23_reg[3:0];
			lane3_eq_code <= eq23_reg[7:4];
			lane_enable <= lane_next;
		end
	end

	// Checks follow.
	property p_txeq_reset;
		@(posedge mclk) disable iff (!resetn)
		!strap_done_reg |-> txeq_reg == RDS_RST_TXEQ && eq01_reg == 8'h00;
	endproperty
	a_txeq_reset: assert property (p_txeq_reset) else $error("shaping reset value wrong");

	property p_pre_gate;
		@(posedge mclk) disable iff (!resetn)
		##1 precursor_on == ($past(txeq_reg[5]) && $past(mode_reg[7]));
	endproperty
	a_pre_gate: assert property (p_pre_gate) else $error("pre-cursor gating wrong");

	property p_post_gate;
		@(posedge mclk) disable iff (!resetn)
		!mode_reg[7] |=> !postcursor_on;
	endproperty
	a_post_gate: assert property (p_post_gate) else $error("post-cursor on in linear mode");

	property p_strap_mirror;
		@(posedge mclk) disable iff (!resetn)
		strap_done_reg && !mode_reg[4] |=> eq23_reg[7:4] == {2'h0, strap_reg};
	endproperty
	a_strap_mirror: assert property (p_strap_mirror) else $error("lane code not strap");

	property p_sw_code;
		@(posedge mclk) disable iff (!resetn)
		wr_pulse && ptr == 8'h10 && mode_reg[4] |=> eq01_reg == $past(wr_data) ##1
			lane1_eq_code == eq01_reg[7:4];
	endproperty
	a_sw_code: assert property (p_sw_code) else $error("software lane code not applied");

	property p_pwr_capture;
		@(posedge mclk) disable iff (!resetn)
		aux_wr_valid && aux_wr_addr == 20'h00600 |=> pwr_reg == $past(aux_wr_data[1:0]);
	endproperty
	a_pwr_capture: assert property (p_pwr_capture) else $error("power state not captured");

	property p_clear_on_off;
		@(posedge mclk) disable iff (!resetn)
		dp_on_d_reg && !dp_on && !aux_wr_valid |=> pwr_reg == 2'h0 && cnt_reg == 5'h00;
	endproperty
	a_clear_on_off: assert property (p_clear_on_off) else $error("snoop fields not cleared");

	property p_snoop_lanes;
		@(posedge mclk) disable iff (!resetn)
		snoop_on && mode_reg[1:0] == 2'h2 && cnt_reg == 5'h2 && pwr_reg == 2'h1
			|=> lane_enable == 4'h3;
	endproperty
	a_snoop_lanes: assert property (p_snoop_lanes) else $error("snooped lanes wrong");

	property p_reg_lanes;
		@(posedge mclk) disable iff (!resetn)
		!snoop_on && mode_reg[1:0] == 2'h2 |=> lane_enable == ~$past(lane_reg[3:0]);
	endproperty
	a_reg_lanes: assert property (p_reg_lanes) else $error("register lanes wrong");

	property p_status_msb;
		@(posedge mclk) disable iff (!resetn)
		ptr == 8'h12 |-> rd_data[7] == 1'b0;
	endproperty
	a_status_msb: assert property (p_status_msb) else $error("status bit 7 not zero");

endmodule

// [tb/rds_aux_source.sv]
// Behavioural display source that issues the sink writes the bank observes.
`timescale 1ns/1ps
module rds_aux_source (
	input wire logic mclk,
	output logic aux_wr_valid,
	output logic [19:0] aux_wr_addr,
	output logic [7:0] aux_wr_data
);
	// Idle lines carry no meaningful address or data.
	initial begin
		aux_wr_valid = 1'b0;
		aux_wr_addr = 20'hfffff;
		aux_wr_data = 8'hff;
	end

	// One write is a single-cycle pulse after a gap of idle cycles.
	// At least one idle edge always separates two writes, so valid never drops and rises
	// again inside one clock period.
	// Afterwards the lines flip, so a stale value is never mistaken for a new write.
	task automatic send(input logic [19:0] a, input logic [7:0] d, input int gap);
		repeat (gap + 1) @(posedge mclk);
		#1;
		aux_wr_valid = 1'b1;
		aux_wr_addr = a;
		aux_wr_data = d;
		@(posedge mclk);
		#1;
		aux_wr_valid = 1'b0;
		aux_wr_addr = ~a;
		aux_wr_data = ~d;
	endtask
endmodule

// [tb/tb_rds_regs.sv]
// Self-checking bench for the redriver register bank with a reference model.
`timescale 1ns/1ps
module tb_rds_regs;
	import rds_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic scl = 1'b1;
	logic sda_m = 1'b1; // Controller drive; high means released.
	logic [1:0] strap = 2'h0;
	logic sda_o, sda_oe, precursor_on, postcursor_on, limited_mode_select, eq_from_registers;
	logic [1:0] precursor_level, postcursor_level, debug_route_ctrl, path_mode_select;
	logic [3:0] lane0_eq_code, lane1_eq_code, lane2_eq_code, lane3_eq_code, lane_enable;
	logic aux_wr_valid;
	logic [19:0] aux_wr_addr;
	logic [7:0] aux_wr_data;
	wire sda_w = sda_m & ~sda_oe; // Pulled-up data line.
	logic [7:0] m_mode, m_tx, m_eq01, m_eq23, m_lane; // Model registers.
	logic [1:0] m_pwr;
	logic [4:0] m_cnt;
	logic [15:0] lfsr = 16'hd830;
	int fail_count = 0;
	int compares = 0;

	// Clock at 200 MHz.
	always #2.5 mclk = ~mclk;

	rds_regs i_rds_regs (.mclk(mclk), .resetn(resetn), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .eq_strap_pins(strap), .aux_wr_valid(aux_wr_valid),
		.aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data),
		.precursor_level(precursor_level), .precursor_on(precursor_on),
		.postcursor_level(postcursor_level), .postcursor_on(postcursor_on),
		.debug_route_ctrl(debug_route_ctrl), .limited_mode_select(limited_mode_select),
		.eq_from_registers(eq_from_registers), .path_mode_select(path_mode_select),
		.lane0_eq_code(lane0_eq_code), .lane1_eq_code(lane1_eq_code),
		.lane2_eq_code(lane2_eq_code), .lane3_eq_code(lane3_eq_code),
		.lane_enable(lane_enable));

	rds_aux_source i_rds_aux_source (.mclk(mclk), .aux_wr_valid(aux_wr_valid),
		.aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data));

	// Pseudo-random byte from a shift register.
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction

	// Model readback of one offset; unmapped offsets read zero.
	function automatic logic [7:0] m_read(input logic [7:0] off);
		case (off)
			8'h0a: return m_mode;
			8'h0b: return m_tx;
			8'h10: return m_eq01;
			8'h11: return m_eq23;
			8'h12: return {1'b0, m_pwr, m_cnt};
			8'h13: return m_lane;
			default: return 8'h00;
		endcase
	endfunction

	// Model write; the status register and unmapped offsets ignore writes.
	task automatic m_write(input logic [7:0] off, input logic [7:0] d);
		case (off)
			8'h0a: begin
				if (m_mode[1] && !d[1]) begin
					m_pwr = 2'h0;
					m_cnt = 5'h00;
				end
				m_mode = d & 8'hbf;
			end
			8'h0b: m_tx = d;
			8'h10: if (m_mode[4]) m_eq01 = d;
			8'h11: if (m_mode[4]) m_eq23 = d;
			8'h13: m_lane = d & 8'hbf;
			default: ;
		endcase
	endtask

	// Model lane enables from the off bits or from the captured values.
	// A path mode without display lanes, or the shared mode above lane 1, keeps a lane off.
	function automatic logic [3:0] m_lanes();
		logic [3:0] e;
		e = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (m_lane[7]) e[i] = !m_lane[i];
			else e[i] = (i < m_cnt) && (m_pwr == 2'h1);
			if (!m_mode[1] || (m_mode[1:0] == 2'h3 && i >= 2)) e[i] = 1'b0;
		end
		return e;
	endfunction

	// Single comparison point.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Wait n edges, then step just past the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One bit on the two-wire bus; the returned level is sampled while the clock is high.
	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		tick(4);
		scl = 1'b1;
		tick(4);
		r = sda_w;
		scl = 1'b0;
		tick(1);
	endtask

	// Start or repeated start.
	task automatic start();
		sda_m = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b0;
		tick(4);
		scl = 1'b0;
		tick(1);
	endtask

	task automatic stop();
		sda_m = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b1;
		tick(4);
	endtask

	// Eight bits out or in, MSB first, then the acknowledge bit.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(1'b1, a);
	endtask

	task automatic reg_wr(input logic [7:0] off, input logic [7:0] d);
		logic [7:0] rx;
		start();
		xfer({RDS_TGT_ADDR, 1'b0}, rx);
		xfer(off, rx);
		xfer(d, rx);
		stop();
		m_write(off, d);
		tick(2);
	endtask

	// Read one offset and compare it with the model.
	task automatic rd_chk(input logic [7:0] off);
		logic [7:0] rx;
		start();
		xfer({RDS_TGT_ADDR, 1'b0}, rx);
		xfer(off, rx);
		start();
		xfer({RDS_TGT_ADDR, 1'b1}, rx);
		xfer(8'hff, rx);
		stop();
		chk({8'h0, rx}, {8'h0, m_read(off)});
	endtask

	// Two-byte write and read bursts, so the pointer must step between bytes.
	task automatic burst_chk(input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1);
		logic [7:0] rx;
		logic a;
		start();
		xfer({RDS_TGT_ADDR, 1'b0}, rx);
		xfer(off, rx);
		xfer(d0, rx);
		xfer(d1, rx);
		stop();
		m_write(off, d0);
		m_write(off + 8'h01, d1);
		tick(2);
		start();
		xfer({RDS_TGT_ADDR, 1'b0}, rx);
		xfer(off, rx);
		start();
		xfer({RDS_TGT_ADDR, 1'b1}, rx);
		// The first byte is acknowledged, so the target goes on with the next offset.
		for (int i = 7; i >= 0; i--) bit_io(1'b1, rx[i]);
		bit_io(1'b0, a);
		chk({8'h0, rx}, {8'h0, m_read(off)});
		xfer(8'hff, rx);
		stop();
		chk({8'h0, rx}, {8'h0, m_read(off + 8'h01)});
	endtask

	// Compare every output except sda_oe with the model.
	task automatic check_outs();
		chk({8'h0, precursor_level, precursor_on, postcursor_level, postcursor_on,
			debug_route_ctrl}, {8'h0, m_tx[7:6], m_tx[5] & m_mode[7], m_tx[4:3],
			m_tx[2] & m_mode[7], m_tx[1:0]});
		chk({11'h0, sda_o, limited_mode_select, eq_from_registers,
			path_mode_select}, {11'h0, 1'b0, m_mode[7], m_mode[4], m_mode[1:0]});
		chk({lane3_eq_code, lane2_eq_code, lane1_eq_code, lane0_eq_code}, {m_eq23, m_eq01});
		chk({12'h0, lane_enable}, {12'h0, m_lanes()});
	endtask

	task automatic close_out();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run length.
	initial begin
		#400000;
		fail_count++;
		close_out();
	end

	// Main sequence.
	initial begin
		logic [7:0] v, w;
		v = rnd();
		strap = v[1:0];
		m_mode = 8'h01;
		m_tx = 8'h6c;
		m_eq01 = {2'h0, strap, 2'h0, strap};
		m_eq23 = m_eq01;
		m_lane = 8'h00;
		m_pwr = 2'h0;
		m_cnt = 5'h00;
		tick(16);
		resetn = 1'b1;
		tick(4);
		check_outs();
		foreach (m_eq01[i]) rd_chk(i == 7 ? 8'h05 : 8'h0a + 8'(i));
		rd_chk(8'h10);
		rd_chk(8'h11);
		rd_chk(8'h12);
		rd_chk(8'h13);
		$display("test reset done");
		// Every level and routing code, first linear then limited.
		for (int k = 0; k < 8; k++) begin
			if (k == 4) reg_wr(8'h0a, 8'h81); // limited mode
			v = rnd();
			reg_wr(8'h0b, {k[1:0], v[5], k[1:0], v[2], k[1:0]});
			rd_chk(8'h0b);
			check_outs();
		end
		$display("test shaping done");
		reg_wr(8'h10, rnd()); // ignored without override
		reg_wr(8'h05, rnd());
		rd_chk(8'h05);
		reg_wr(8'h0a, 8'h92); // override first
		reg_wr(8'h10, rnd());
		reg_wr(8'h11, rnd());
		reg_wr(8'h12, rnd()); // write ignored
		rd_chk(8'h10);
		rd_chk(8'h11);
		rd_chk(8'h12);
		check_outs();
		burst_chk(8'h10, rnd(), rnd());
		check_outs();
		$display("test lane codes done");
		// Counts 0 to 5 and one foreign power state, with varied gaps.
		for (int k = 0; k < 6; k++) begin
			v = rnd();
			w = rnd();
			i_rds_aux_source.send(20'h00101, {v[7:5], 5'(k)}, k);
			m_cnt = 5'(k);
			i_rds_aux_source.send(20'h00600, {w[7:2], k == 3 ? 2'h2 : 2'h1}, 0);
			m_pwr = k == 3 ? 2'h2 : 2'h1;
			i_rds_aux_source.send(20'h00102, v, 1);
			tick(3);
			check_outs();
			rd_chk(8'h12);
		end
		reg_wr(8'h0a, 8'h93); // two display lanes
		check_outs();
		reg_wr(8'h0a, 8'h91); // path off
		rd_chk(8'h12);
		check_outs();
		reg_wr(8'h0a, 8'h92);
		v = rnd();
		reg_wr(8'h13, {1'b1, v[6:0]}); // register enables
		rd_chk(8'h13);
		check_outs();
		$display("test snoop done");
		close_out();
	end
endmodule
